// >>> core/pmbus_status_aggregation.sv
`timescale 1ns/1ns
module pmbus_status_aggregation #(
  parameter logic [15:0] PG_SETUP_DEFAULT = status_agg_pkg::PG_SETUP_RESET
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic [7:0] i_cmd,
  input wire status_agg_pkg::xfer_kind_t i_kind,
  input wire logic [15:0] i_wr_data,
  input wire logic [7:0] i_phase,
  input wire logic [7:0] i_status_vout,
  input wire logic [7:0] i_status_iout,
  input wire logic [7:0] i_status_input,
  input wire logic [7:0] i_status_temp,
  input wire logic [7:0] i_status_cml,
  input wire logic [7:0] i_status_other,
  input wire logic [7:0] i_status_mfr,
  input wire logic [status_agg_pkg::NUM_PHASES-1:0] i_phase_fault_evt,
  input wire logic [status_agg_pkg::NUM_PHASES-1:0] i_phase_status_any,
  input wire logic [status_agg_pkg::NUM_PHASES-1:0] i_phase_enabled,
  input wire logic i_conversion_en,
  input wire logic i_clear_faults,
  input wire logic i_smbalert,
  output logic o_rd_valid,
  output logic o_rd_hit,
  output logic [2:0] o_rd_len,
  output logic [55:0] o_rd_data,
  output logic o_invalid_command_flag,
  output logic o_cml_summary,
  output logic [15:0] o_power_good_setup,
  output logic o_smbalert,
  output logic o_smbalert_oe_n
);
  import status_agg_pkg::*;

  // Registered outputs
  logic rd_valid_ff;
  logic rd_hit_ff;
  logic [2:0] rd_len_ff;
  logic [55:0] rd_data_ff;
  logic ivc_ff; // Sticky invalid command flag
  logic [15:0] pg_setup_ff; // Power-good setup word
  logic alert_oe_n_ff; // Low while the alert line is pulled
  localparam logic [2:0] ALERT_SYNC_IDLE = 3'h7; // Pulled-up line idles high
  logic [2:0] alert_sync_ff; // Alert wire through three flops
  logic alert_level_ff; // Alert level once the last two flops agree
  logic nxt_ivc;
  logic [55:0] nxt_rd_data;
  logic [2:0] nxt_rd_len;
  logic nxt_rd_hit;

  // Command decode
  wire hit_sum = (i_cmd == CMD_FAULT_SUMMARY);
  wire hit_map = (i_cmd == CMD_PHASE_FAULT_MAP);
  wire hit_pg = (i_cmd == CMD_POWER_GOOD_SETUP);
  wire is_word = (i_kind == XFER_WORD);
  wire is_block = (i_kind == XFER_BLOCK);

  // Any write aimed at the summary is refused outright
  wire bad_sum_wr = i_wr_req && hit_sum;
  // Summary answers a block read only
  wire bad_sum_rd = i_rd_req && hit_sum && !is_block;
  // Phase map answers words only
  wire bad_map = (i_wr_req || i_rd_req) && hit_map && !is_word;
  // Locked power-good write, or power-good read or write that is not a word
  wire bad_pg = (i_wr_req || i_rd_req) && hit_pg && (!is_word || (i_wr_req && i_conversion_en));
  wire raise_ivc = bad_sum_wr || bad_sum_rd || bad_map || bad_pg;

  // Phase selection decode; numbers outside the stack select nothing
  wire sel_all = (i_phase == PHASE_ALL);
  wire sel_in_range = (i_phase < 8'(NUM_PHASES));
  wire [1:0] sel_idx = i_phase[1:0];

  // Writes of ones to the map clear history; single-phase uses bit 0
  wire map_wr = i_wr_req && hit_map && is_word;
  wire [NUM_PHASES-1:0] sel_onehot = NUM_PHASES'(1) << sel_idx;
  wire [NUM_PHASES-1:0] map_clr = !map_wr ? '0 :
    sel_all ? i_wr_data[NUM_PHASES-1:0] :
    (sel_in_range && i_wr_data[0]) ? sel_onehot : '0;
  wire [NUM_PHASES-1:0] fault_map;

  // CML byte as seen by the host includes our own invalid flag
  wire [7:0] cml_view = i_status_cml | (8'(ivc_ff) << INVALID_COMMAND_FLAG_BIT);

  // Word returned by the phase fault map
  wire single_any = sel_in_range && i_phase_status_any[sel_idx] && i_phase_enabled[sel_idx];
  wire [15:0] map_word = sel_all ? 16'(fault_map) : 16'(single_any);

  // Seven status bytes, least significant lane first
  wire [55:0] sum_block = {i_status_mfr, i_status_other, cml_view, i_status_temp,
    i_status_input, i_status_iout, i_status_vout};

  phase_fault_tracker #(
    .PHASES(NUM_PHASES)
  ) u_tracker (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_fault_evt(i_phase_fault_evt),
    .i_clear_mask(map_clr),
    .i_phase_enabled(i_phase_enabled),
    .o_fault_map(fault_map)
  );

  // Read answer selection
  always_comb begin
    nxt_rd_data = RD_DATA_RESET;
    nxt_rd_len = LEN_NONE;
    nxt_rd_hit = 1'b0;
    if (hit_sum && is_block) begin
      nxt_rd_data = sum_block;
      nxt_rd_len = LEN_FAULT_SUMMARY;
      nxt_rd_hit = 1'b1;
    end else if (hit_map && is_word) begin
      nxt_rd_data = 56'(map_word);
      nxt_rd_len = LEN_WORD;
      nxt_rd_hit = 1'b1;
    end else if (hit_pg && is_word) begin
      nxt_rd_data = 56'(pg_setup_ff);
      nxt_rd_len = LEN_WORD;
      nxt_rd_hit = 1'b1;
    end
  end

  // Flag set wins over a clear in the same cycle; a summary write never clears
  assign nxt_ivc = raise_ivc || (ivc_ff && !i_clear_faults);

  // Read answer registers, one cycle after the request
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rd_valid_ff <= 1'b0;
      rd_hit_ff <= 1'b0;
      rd_len_ff <= LEN_NONE;
      rd_data_ff <= RD_DATA_RESET;
    end else begin
      rd_valid_ff <= i_rd_req;
      rd_hit_ff <= i_rd_req && nxt_rd_hit;
      rd_len_ff <= i_rd_req ? nxt_rd_len : LEN_NONE;
      rd_data_ff <= i_rd_req ? nxt_rd_data : RD_DATA_RESET;
    end
  end

  // Flag, alert and stored configuration
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      ivc_ff <= 1'b0;
      alert_oe_n_ff <= 1'b1;
      pg_setup_ff <= PG_SETUP_DEFAULT;
    end else begin
      ivc_ff <= nxt_ivc;
      // Line pulled low while the flag stands, released on clear
      alert_oe_n_ff <= !nxt_ivc;
      if (i_wr_req && hit_pg && is_word && !i_conversion_en) begin
        pg_setup_ff <= i_wr_data;
      end
    end
  end

  // Alert wire is a pin from outside our clock; a change counts once two flops agree
  // Idle-high reset avoids a false falling edge right after reset
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      alert_sync_ff <= ALERT_SYNC_IDLE;
      alert_level_ff <= 1'b1;
    end else begin
      alert_sync_ff <= {alert_sync_ff[1:0], i_smbalert};
      if (alert_sync_ff[1] == alert_sync_ff[2]) begin
        alert_level_ff <= alert_sync_ff[2];
      end
    end
  end

  assign o_rd_valid = rd_valid_ff;
  assign o_rd_hit = rd_hit_ff;
  assign o_rd_len = rd_len_ff;
  assign o_rd_data = rd_data_ff;
  assign o_invalid_command_flag = ivc_ff;
  // CML bit of the status byte reflects our own invalid command flag
  assign o_cml_summary = ivc_ff;
  assign o_power_good_setup = pg_setup_ff;
  // Open-drain: only ever drives low
  assign o_smbalert = 1'b0;
  assign o_smbalert_oe_n = alert_oe_n_ff;

  a_sum_write_flag: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_wr_req && hit_sum) |=> (ivc_ff && !alert_oe_n_ff))
    else $error("summary write not flagged");
  a_alert_follows: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    ivc_ff == !alert_oe_n_ff)
    else $error("alert disagrees with flag");
  a_sum_no_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (ivc_ff && !i_clear_faults) |=> ivc_ff)
    else $error("flag dropped without clear");
  a_sum_read: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_rd_req && hit_sum && is_block) |=> (o_rd_len == LEN_FAULT_SUMMARY
    && o_rd_data[LANE_VOUT +: 8] == $past(i_status_vout)
    && o_rd_data[LANE_MFR +: 8] == $past(i_status_mfr)))
    else $error("summary block wrong");
  a_sum_block_only: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_rd_req && hit_sum && !is_block) |=> (!o_rd_hit && ivc_ff))
    else $error("summary answered non-block read");
  a_map_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_rd_req && hit_map && is_word) |=> (o_rd_data[55:NUM_PHASES] == '0
    && o_rd_len == LEN_WORD))
    else $error("phase map upper bits set");
  a_map_unused_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_rd_req && hit_map && is_word && sel_all) |=>
    ((o_rd_data[NUM_PHASES-1:0] & ~$past(i_phase_enabled)) == '0))
    else $error("disabled phase reads one");
  a_single_phase: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_rd_req && hit_map && is_word && !sel_all) |=>
    (o_rd_data[0] == $past(single_any) && o_rd_data[55:1] == '0))
    else $error("single phase word wrong");
  a_pg_locked: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_wr_req && hit_pg && i_conversion_en) |=>
    (pg_setup_ff == $past(pg_setup_ff) && ivc_ff))
    else $error("locked setup changed");
  a_pg_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_wr_req && hit_pg && is_word && !i_conversion_en) |=>
    pg_setup_ff == $past(i_wr_data))
    else $error("setup write lost");

  c_sum_read: cover property (@(posedge i_mclk) i_rd_req && hit_sum && is_block);
  c_map_all: cover property (@(posedge i_mclk) i_rd_req && hit_map && sel_all && |fault_map);
  c_pg_locked: cover property (@(posedge i_mclk) i_wr_req && hit_pg && i_conversion_en);
  c_alert_seen: cover property (@(posedge i_mclk) !alert_oe_n_ff && !alert_level_ff);
endmodule : pmbus_status_aggregation

// >>> core/status_agg_pkg.sv
package status_agg_pkg;
  // Command codes served by this block
  localparam logic [7:0] CMD_FAULT_SUMMARY = 8'hDB;
  localparam logic [7:0] CMD_PHASE_FAULT_MAP = 8'hDC;
  localparam logic [7:0] CMD_POWER_GOOD_SETUP = 8'hE3;
  // PHASE value that addresses every stacked phase
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  // Stack size and answer sizes in bytes
  localparam int NUM_PHASES = 4;
  localparam logic [2:0] LEN_FAULT_SUMMARY = 3'h7;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_NONE = 3'h0;
  // Byte lanes of the fault summary block, least significant first
  localparam int LANE_VOUT = 0;
  localparam int LANE_IOUT = 8;
  localparam int LANE_INPUT = 16;
  localparam int LANE_TEMP = 24;
  localparam int LANE_CML = 32;
  localparam int LANE_OTHER = 40;
  localparam int LANE_MFR = 48;
  // Invalid command flag position inside the CML status byte
  localparam int INVALID_COMMAND_FLAG_BIT = 7;
  // Reset values
  localparam logic [15:0] PHASE_MAP_RESET = 16'h0000;
  localparam logic [15:0] PG_SETUP_RESET = 16'h0000;
  localparam logic [55:0] RD_DATA_RESET = 56'h0;
  // Transaction kinds reported by the protocol engine
  typedef enum logic [1:0] {
    XFER_BYTE = 2'b00,
    XFER_WORD = 2'b01,
    XFER_BLOCK = 2'b10,
    XFER_SEND = 2'b11
  } xfer_kind_t;
endpackage : status_agg_pkg

// >>> core/phase_fault_tracker.sv
`timescale 1ns/1ns
// Sticky per-phase fault history; unused phases always read zero
module phase_fault_tracker #(
  parameter int PHASES = 4
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [PHASES-1:0] i_fault_evt,
  input wire logic [PHASES-1:0] i_clear_mask,
  input wire logic [PHASES-1:0] i_phase_enabled,
  output logic [PHASES-1:0] o_fault_map
);
  import status_agg_pkg::*;

  logic [PHASES-1:0] history_ff; // Fault seen since last clear
  logic [PHASES-1:0] nxt_history;

  // Set wins over a clear landing in the same cycle
  assign nxt_history = (history_ff & ~i_clear_mask) | i_fault_evt;
  // Unassigned or disabled phases are forced to zero
  assign o_fault_map = history_ff & i_phase_enabled;

  // History register, cleared by reset
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      history_ff <= PHASE_MAP_RESET[PHASES-1:0];
    end else begin
      history_ff <= nxt_history;
    end
  end

  a_set_wins: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    |i_fault_evt |=> ((history_ff & $past(i_fault_evt)) == $past(i_fault_evt)))
    else $error("phase fault event lost");
endmodule : phase_fault_tracker

// >>> tb/pmbus_host_model.sv
`timescale 1ns/1ns
// Host controller model: one transfer at a time, launched on falling edges
module pmbus_host_model (
  input wire logic i_mclk,
  output logic o_wr_req,
  output logic o_rd_req,
  output logic [7:0] o_cmd,
  output status_agg_pkg::xfer_kind_t o_kind,
  output logic [15:0] o_wr_data,
  output logic [7:0] o_phase,
  input wire logic i_rd_valid,
  input wire logic i_rd_hit,
  input wire logic [2:0] i_rd_len,
  input wire logic [55:0] i_rd_data
);
  import status_agg_pkg::*;
  // Idle bus at time zero
  initial begin
    o_wr_req = 1'b0;
    o_rd_req = 1'b0;
    o_cmd = 8'h00;
    o_kind = XFER_BYTE;
    o_wr_data = 16'h0000;
    o_phase = PHASE_ALL;
  end
  // Select a phase before asking for its details
  task automatic set_phase(input logic [7:0] p);
    @(negedge i_mclk);
    o_phase = p;
  endtask : set_phase
  // Caller picks the kind; the task drives whatever kind it is given
  task automatic xfer(input logic wr, input logic [7:0] cmd, input xfer_kind_t kind,
                      input logic [15:0] data, output logic [60:0] ans);
    @(negedge i_mclk);
    o_wr_req = wr;
    o_rd_req = !wr;
    o_cmd = cmd;
    o_kind = kind;
    o_wr_data = data;
    @(negedge i_mclk);
    // Answer stands only in the cycle after the request; take it before it drops
    ans = {i_rd_valid, i_rd_hit, i_rd_len, i_rd_data};
    o_wr_req = 1'b0;
    o_rd_req = 1'b0;
    // Released fields flip so a stale copy is never taken for a live one
    o_cmd = ~cmd;
    o_kind = xfer_kind_t'(~kind);
    o_wr_data = ~data;
  endtask : xfer
endmodule : pmbus_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench: host model on the transaction port, status sources here
module tb_top;
  import status_agg_pkg::*;
  logic mclk, reset_n, wr_req, rd_req, conv_en, clr, oe_n, alert_out, flag, cml;
  logic rd_valid, rd_hit;
  logic [7:0] cmd, phase, sv, si, sn, st, sc, so, sm;
  logic [15:0] wdata, setup;
  logic [3:0] evt, any, en;
  logic [2:0] rd_len;
  logic [55:0] rd_data;
  logic [60:0] ans;
  xfer_kind_t kind;
  int errors = 0;
  int checked = 0;
  // Alert wire has a pull-up: high unless the block pulls it down
  wire logic alert_wire = oe_n ? 1'b1 : alert_out;

  pmbus_host_model pmbus_host_model_inst (
    .i_mclk(mclk), .o_wr_req(wr_req), .o_rd_req(rd_req), .o_cmd(cmd), .o_kind(kind),
    .o_wr_data(wdata), .o_phase(phase), .i_rd_valid(rd_valid), .i_rd_hit(rd_hit),
    .i_rd_len(rd_len), .i_rd_data(rd_data));
  pmbus_status_aggregation pmbus_status_aggregation_inst (
    .i_mclk(mclk), .i_reset_n(reset_n), .i_wr_req(wr_req), .i_rd_req(rd_req),
    .i_cmd(cmd), .i_kind(kind), .i_wr_data(wdata), .i_phase(phase),
    .i_status_vout(sv), .i_status_iout(si), .i_status_input(sn), .i_status_temp(st),
    .i_status_cml(sc), .i_status_other(so), .i_status_mfr(sm),
    .i_phase_fault_evt(evt), .i_phase_status_any(any), .i_phase_enabled(en),
    .i_conversion_en(conv_en), .i_clear_faults(clr), .i_smbalert(alert_wire),
    .o_rd_valid(rd_valid), .o_rd_hit(rd_hit), .o_rd_len(rd_len), .o_rd_data(rd_data),
    .o_invalid_command_flag(flag), .o_cml_summary(cml), .o_power_good_setup(setup),
    .o_smbalert(alert_out), .o_smbalert_oe_n(oe_n));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Expected summary, VOUT in the low byte, flag folded into the CML byte
  function automatic logic [55:0] blk(input logic f);
    return {sm, so, sc | {f, 7'h00}, st, sn, si, sv};
  endfunction : blk
  // Compare and count
  task automatic check(input logic [60:0] seen, input logic [60:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] c, input xfer_kind_t k);
    pmbus_host_model_inst.xfer(1'b0, c, k, 16'h0000, ans);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    pmbus_host_model_inst.xfer(1'b1, c, XFER_WORD, d, ans);
  endtask : wr
  // One-cycle clear pulse, launched on a falling edge
  task automatic pulse_clear();
    @(negedge mclk);
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
  endtask : pulse_clear
  // Single exit for both the tests and the watchdog
  task automatic conclude();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // Watchdog: the tests need well under a hundred cycles
  initial begin
    repeat (1000) @(posedge mclk);
    errors++;
    conclude();
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    conv_en = 1'b0;
    clr = 1'b0;
    evt = 4'h0;
    any = 4'h6;
    en = 4'h7;
    {sm, so, sc, st, sn, si, sv} = 56'hF6E502D4C3B2A1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    check({flag, cml, oe_n, setup}, {3'b001, PG_SETUP_RESET});
    rd(CMD_PHASE_FAULT_MAP, XFER_WORD);
    check(ans, {2'b11, LEN_WORD, 56'h0});
    rd(CMD_FAULT_SUMMARY, XFER_BLOCK);
    check(ans, {2'b11, LEN_FAULT_SUMMARY, blk(1'b0)});
    rd(CMD_FAULT_SUMMARY, XFER_WORD);
    check(ans[60:59], 2'b10);
    check({flag, cml, oe_n}, 3'b110);
    // Clear first so the summary write below has to raise the flag itself
    pulse_clear();
    check({flag, cml, oe_n}, 3'b001);
    wr(CMD_FAULT_SUMMARY, 16'hFFFF);
    check({flag, cml, oe_n, alert_wire}, 4'b1100);
    rd(CMD_FAULT_SUMMARY, XFER_BLOCK);
    check(ans, {2'b11, LEN_FAULT_SUMMARY, blk(1'b1)});
    pulse_clear();
    check({flag, cml, oe_n}, 3'b001);
    // Fault on phases 0, 1 and 3; phase 3 is disabled
    @(negedge mclk);
    evt = 4'hB;
    @(negedge mclk);
    evt = 4'h0;
    rd(CMD_PHASE_FAULT_MAP, XFER_WORD);
    check(ans, {2'b11, LEN_WORD, 56'h3});
    for (int p = 0; p < 5; p++) begin
      pmbus_host_model_inst.set_phase(8'(p));
      rd(CMD_PHASE_FAULT_MAP, XFER_WORD);
      check(ans, {2'b11, LEN_WORD, 55'h0, p < 4 && any[p] && en[p]});
    end
    pmbus_host_model_inst.set_phase(PHASE_ALL);
    wr(CMD_PHASE_FAULT_MAP, 16'h0001);
    rd(CMD_PHASE_FAULT_MAP, XFER_WORD);
    check(ans, {2'b11, LEN_WORD, 56'h2});
    rd(CMD_PHASE_FAULT_MAP, XFER_BLOCK);
    check(ans[60:59], 2'b10);
    wr(CMD_POWER_GOOD_SETUP, 16'h1234);
    rd(CMD_POWER_GOOD_SETUP, XFER_WORD);
    check(ans, {2'b11, LEN_WORD, 56'h1234});
    // Flag was left set by the refused block read; clear it before the lock test
    pulse_clear();
    check({flag, cml, oe_n}, 3'b001);
    @(negedge mclk);
    conv_en = 1'b1;
    wr(CMD_POWER_GOOD_SETUP, 16'h5678);
    check({flag, setup}, {1'b1, 16'h1234});
    rd(CMD_POWER_GOOD_SETUP, XFER_WORD);
    check(ans, {2'b11, LEN_WORD, 56'h1234});
    // Mid-run reset: history, flag and setup all return to their reset values
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    check({flag, cml, oe_n, setup}, {3'b001, PG_SETUP_RESET});
    rd(CMD_PHASE_FAULT_MAP, XFER_WORD);
    check(ans, {2'b11, LEN_WORD, 56'h0});
    conclude();
  end
endmodule : tb_top
